// >>> ssv_pkg.sv
// Shared types and constants of the supply reset supervisor.
// Assumes a 200 MHz timer clock and a separate free-running link clock.
package ssv_pkg;

	typedef struct packed {
		logic scl;
		logic sda;
	} ssv_lines_type;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_TIME = 3'b010,
		ST_RUN = 3'b100
	} ssv_state_type;

	localparam longint unsigned PS_PER_MS = 64'd1000000000;
	localparam int unsigned MCLK_PERIOD_PS = 32'd5000;
	localparam int unsigned LCLK_PERIOD_PS = 32'd15000;

	// Reset timeout, nominal figure used; 130 to 270 ms allowed
	localparam int unsigned RST_TIMEOUT_MIN_MS = 32'd130;
	localparam int unsigned RST_TIMEOUT_MS = 32'd200;
	localparam int unsigned RST_TIMEOUT_MAX_MS = 32'd270;
	localparam int unsigned RST_TIMEOUT_CYC =
		32'(RST_TIMEOUT_MS * PS_PER_MS / MCLK_PERIOD_PS);

	// Longest supply-loss to reset delay, rounded down
	localparam int unsigned THRESHOLD_TO_RESET_DELAY_NS = 32'd5000;
	localparam int unsigned THRESHOLD_TO_RESET_DELAY_CYC =
		THRESHOLD_TO_RESET_DELAY_NS * 1000 / MCLK_PERIOD_PS;

	// Rejection widths: must stay stable for more than the figure
	localparam int unsigned SUPPLY_GLITCH_REJECT_WIDTH_NS = 32'd30;
	localparam int unsigned SUPPLY_FILT_CYC =
		SUPPLY_GLITCH_REJECT_WIDTH_NS * 1000 / MCLK_PERIOD_PS + 1;
	localparam int unsigned MANUAL_RESET_GLITCH_NS = 32'd100;
	localparam int unsigned MANUAL_RESET_FILT_CYC =
		MANUAL_RESET_GLITCH_NS * 1000 / MCLK_PERIOD_PS + 1;
	localparam int unsigned MANUAL_RESET_MIN_WIDTH_NS = 32'd5000;
	localparam int unsigned MANUAL_RESET_MIN_WIDTH_CYC =
		MANUAL_RESET_MIN_WIDTH_NS * 1000 / MCLK_PERIOD_PS;
	localparam int unsigned INPUT_SPIKE_LIMIT_NS = 32'd100;
	// Round up: a spike can straddle one more sample than its length
	localparam int unsigned SPIKE_FILT_CYC =
		(INPUT_SPIKE_LIMIT_NS * 1000 + LCLK_PERIOD_PS - 1) / LCLK_PERIOD_PS + 1;

	// Internal write cycle, longest time rounded down
	localparam int unsigned WRITE_CYCLE_TIME_MS = 32'd5;
	localparam int unsigned WRITE_CYCLE_CYC =
		32'(WRITE_CYCLE_TIME_MS * PS_PER_MS / MCLK_PERIOD_PS);

	// Host side wait before first memory access
	localparam int unsigned POWERUP_TO_ACCESS_DELAY_MS = 32'd270;

	localparam int unsigned CNT_W = 32;

endpackage : ssv_pkg

// >>> ssv_sync.sv
// Two-stage level synchroniser, any width.
// Assumes bits are independent levels; no word coherency.
`timescale 1ns/1ps
`default_nettype none
module ssv_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= RST_VAL;
			q_o <= RST_VAL;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : ssv_sync
`default_nettype wire

// >>> ssv_filter.sv
// Stability filter: output follows input after N equal samples.
// Assumes a synchronised input; shorter excursions are dropped.
`timescale 1ns/1ps
`default_nettype none
module ssv_filter #(
	parameter int N = 7,
	parameter logic INIT = 1'b0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	localparam int W = $clog2(N + 1);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
			q_o <= INIT;
		end else if (d_i == q_o) begin
			cnt_q <= '0;
		end else if (cnt_q == W'(N - 1)) begin
			cnt_q <= '0;
			q_o <= d_i;
		end else begin
			cnt_q <= cnt_q + W'(1);
		end
	end
endmodule : ssv_filter
`default_nettype wire

// >>> ssv_supervisor.sv
// Supply reset supervisor: reset timing, input filters, write lockout.
// Assumes an analog comparator level, an open-drain reset pin with
// pull-up, and a two-wire bus engine on the link clock beside it.
`timescale 1ns/1ps
`default_nettype none
module ssv_supervisor #(
	parameter int unsigned TIMEOUT_CYC = ssv_pkg::RST_TIMEOUT_CYC,
	parameter int unsigned WRCYC_CYC = ssv_pkg::WRITE_CYCLE_CYC
) (
	input wire logic MCLK_I,
	input wire logic RST_N_I,
	input wire logic LCLK_I,
	input wire logic LRST_N_I,
	input wire logic SUPPLY_GOOD_I,
	input wire logic RST_PIN_I,
	output logic RST_PIN_O,
	output logic RST_PIN_OE_O,
	output logic WRCYC_BUSY_O,
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	input wire logic SDA_DRIVE_I,
	input wire logic WR_DATA_I,
	output ssv_pkg::ssv_lines_type LINES_O,
	output logic START_O,
	output logic STOP_O,
	output logic BUS_EN_O
);
	// Timer domain
	logic supply_s;
	logic supply_f;
	logic manual_reset_s;
	logic manual_reset_f;
	logic manual_reset_prev_q;
	logic manual_fall;
	ssv_pkg::ssv_state_type st_q;
	ssv_pkg::ssv_state_type st_d;
	logic [ssv_pkg::CNT_W-1:0] cnt_q;
	logic rst_active_q;
	logic rst_oe_q;
	logic wrcyc_busy_q;
	logic [ssv_pkg::CNT_W-1:0] wrcyc_cnt_q;
	logic req_tgl_s;
	logic req_seen_q;
	logic req_evt;
	logic ack_tgl_q;
	// Link domain
	ssv_pkg::ssv_lines_type raw_s;
	ssv_pkg::ssv_lines_type filt;
	ssv_pkg::ssv_lines_type prev_q;
	logic lrst_active_s;
	logic lbusy_s;
	logic ack_tgl_s;
	logic req_tgl_q;
	logic pend_q;
	logic pend_dly_q;
	logic start_d;
	logic stop_d;
	logic lines_start_q;
	logic lines_stop_q;
	logic bus_en_q;
	logic sda_oe_q;
	ssv_pkg::ssv_lines_type lines_q;

	// Comparator and pin are asynchronous to the timer
	ssv_sync #(.W(1), .RST_VAL(1'b0)) u_sync_supply (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(SUPPLY_GOOD_I),
		.q_o(supply_s)
	);

	ssv_sync #(.W(1), .RST_VAL(1'b1)) u_sync_manual (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(RST_PIN_I),
		.q_o(manual_reset_s)
	);

	// Supply reads bad from reset so the output starts asserted
	ssv_filter #(.N(ssv_pkg::SUPPLY_FILT_CYC), .INIT(1'b0)) u_filt_supply (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(supply_s),
		.q_o(supply_f)
	);

	ssv_filter #(.N(ssv_pkg::MANUAL_RESET_FILT_CYC), .INIT(1'b1)) u_filt_man (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(manual_reset_s),
		.q_o(manual_reset_f)
	);

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			manual_reset_prev_q <= 1'b1;
		end else begin
			manual_reset_prev_q <= manual_reset_f;
		end
	end

	// Own drive also pulls the pin low; only edges seen while released count
	assign manual_fall = manual_reset_prev_q && !manual_reset_f;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ssv_pkg::ST_HOLD: begin
				if (supply_f) begin
					st_d = ssv_pkg::ST_TIME;
				end
			end
			ssv_pkg::ST_TIME: begin
				if (!supply_f) begin
					st_d = ssv_pkg::ST_HOLD;
				end else if (cnt_q == ssv_pkg::CNT_W'(TIMEOUT_CYC - 1)) begin
					st_d = ssv_pkg::ST_RUN;
				end
			end
			ssv_pkg::ST_RUN: begin
				if (!supply_f) begin
					st_d = ssv_pkg::ST_HOLD;
				end else if (manual_fall) begin
					st_d = ssv_pkg::ST_TIME;
				end
			end
			default: begin
				st_d = ssv_pkg::ST_HOLD;
			end
		endcase
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			st_q <= ssv_pkg::ST_HOLD;
		end else begin
			st_q <= st_d;
		end
	end

	// Timeout restarts on every entry to the timing state
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			cnt_q <= '0;
		end else if (st_q != ssv_pkg::ST_TIME || st_d != ssv_pkg::ST_TIME) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + ssv_pkg::CNT_W'(1);
		end
	end

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			rst_active_q <= 1'b1;
			rst_oe_q <= 1'b1;
		end else begin
			rst_active_q <= (st_d != ssv_pkg::ST_RUN);
			rst_oe_q <= (st_d != ssv_pkg::ST_RUN);
		end
	end

	// Open drain: only ever pulls low
	assign RST_PIN_O = 1'b0;
	assign RST_PIN_OE_O = rst_oe_q;

	// Write request from link domain arrives as a toggle
	ssv_sync #(.W(1), .RST_VAL(1'b0)) u_sync_req (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.d_i(req_tgl_q),
		.q_o(req_tgl_s)
	);

	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			req_seen_q <= 1'b0;
		end else begin
			req_seen_q <= req_tgl_s;
		end
	end

	assign req_evt = req_tgl_s ^ req_seen_q;

	// Reset refuses new writes but never cuts one short
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			wrcyc_busy_q <= 1'b0;
			wrcyc_cnt_q <= '0;
		end else if (req_evt && !rst_active_q && !wrcyc_busy_q) begin
			wrcyc_busy_q <= 1'b1;
			wrcyc_cnt_q <= '0;
		end else if (wrcyc_busy_q) begin
			if (wrcyc_cnt_q == ssv_pkg::CNT_W'(WRCYC_CYC - 1)) begin
				wrcyc_busy_q <= 1'b0;
			end
			wrcyc_cnt_q <= wrcyc_cnt_q + ssv_pkg::CNT_W'(1);
		end
	end

	// Acknowledge every request, taken or refused
	always_ff @(posedge MCLK_I) begin
		if (!RST_N_I) begin
			ack_tgl_q <= 1'b0;
		end else if (req_evt) begin
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	assign WRCYC_BUSY_O = wrcyc_busy_q;

	// Link side
	ssv_sync #(.W(2), .RST_VAL(2'b11)) u_sync_lines (
		.clk_i(LCLK_I),
		.rst_n_i(LRST_N_I),
		.d_i({SCL_I, SDA_I}),
		.q_o(raw_s)
	);

	ssv_filter #(.N(ssv_pkg::SPIKE_FILT_CYC), .INIT(1'b1)) u_filt_scl (
		.clk_i(LCLK_I),
		.rst_n_i(LRST_N_I),
		.d_i(raw_s.scl),
		.q_o(filt.scl)
	);

	ssv_filter #(.N(ssv_pkg::SPIKE_FILT_CYC), .INIT(1'b1)) u_filt_sda (
		.clk_i(LCLK_I),
		.rst_n_i(LRST_N_I),
		.d_i(raw_s.sda),
		.q_o(filt.sda)
	);

	ssv_sync #(.W(3), .RST_VAL(3'b100)) u_sync_state (
		.clk_i(LCLK_I),
		.rst_n_i(LRST_N_I),
		.d_i({rst_active_q, wrcyc_busy_q, ack_tgl_q}),
		.q_o({lrst_active_s, lbusy_s, ack_tgl_s})
	);

	assign start_d = prev_q.scl && filt.scl && prev_q.sda && !filt.sda;
	assign stop_d = prev_q.scl && filt.scl && !prev_q.sda && filt.sda;

	always_ff @(posedge LCLK_I) begin
		if (!LRST_N_I) begin
			prev_q <= '1;
			lines_q <= '1;
			lines_start_q <= 1'b0;
			lines_stop_q <= 1'b0;
		end else begin
			prev_q <= filt;
			lines_q <= filt;
			lines_start_q <= start_d && !lrst_active_s;
			lines_stop_q <= stop_d;
		end
	end

	// Stop after write data asks for a write cycle unless in reset or a request is still pending
	always_ff @(posedge LCLK_I) begin
		if (!LRST_N_I) begin
			req_tgl_q <= 1'b0;
		end else if (stop_d && WR_DATA_I && !lrst_active_s && !pend_q) begin
			req_tgl_q <= ~req_tgl_q;
		end
	end

	// Busy and ack cross on separate flops; one extra cycle covers skew
	always_ff @(posedge LCLK_I) begin
		if (!LRST_N_I) begin
			pend_q <= 1'b0;
			pend_dly_q <= 1'b0;
		end else begin
			pend_q <= (req_tgl_q != ack_tgl_s);
			pend_dly_q <= pend_q;
		end
	end

	always_ff @(posedge LCLK_I) begin
		if (!LRST_N_I) begin
			bus_en_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			bus_en_q <= !(lrst_active_s || lbusy_s || pend_q || pend_dly_q ||
				(req_tgl_q != ack_tgl_s));
			sda_oe_q <= SDA_DRIVE_I && bus_en_q && !lrst_active_s && !lbusy_s;
		end
	end

	assign SDA_O = 1'b0;
	assign SDA_OE_O = sda_oe_q;
	assign LINES_O = lines_q;
	assign START_O = lines_start_q;
	assign STOP_O = lines_stop_q;
	assign BUS_EN_O = bus_en_q;

	// Checks, timer domain
	property p_hold;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		!supply_f |=> rst_active_q && RST_PIN_OE_O;
	endproperty
	a_hold: assert property (p_hold) else $error("reset not held");

	property p_release;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		$fell(rst_active_q) |-> $past(cnt_q) == ssv_pkg::CNT_W'(TIMEOUT_CYC - 1)
			&& $past(st_q) == ssv_pkg::ST_TIME;
	endproperty
	a_release: assert property (p_release) else $error("early release");

	property p_loss;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		!supply_s [*7] |-> ##[0:3] RST_PIN_OE_O;
	endproperty
	a_loss: assert property (p_loss) else $error("slow reset on loss");

	property p_dip;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		supply_f && supply_s ##1 !supply_s [*6] ##1 supply_s |=> supply_f;
	endproperty
	a_dip: assert property (p_dip) else $error("short dip taken");

	property p_manual_width;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		$fell(manual_reset_f) |-> !$past(manual_reset_s, 1)
			&& !$past(manual_reset_s, 20);
	endproperty
	a_manual_width: assert property (p_manual_width) else $error("short manual");

	property p_manual_edge;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		st_q == ssv_pkg::ST_RUN && supply_f && manual_fall
			|=> st_q == ssv_pkg::ST_TIME && cnt_q == '0 ##1 rst_active_q;
	endproperty
	a_manual_edge: assert property (p_manual_edge) else $error("no timeout");

	property p_wrcyc;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		wrcyc_busy_q && wrcyc_cnt_q == ssv_pkg::CNT_W'(WRCYC_CYC - 1)
			|=> !wrcyc_busy_q;
	endproperty
	a_wrcyc: assert property (p_wrcyc) else $error("write cycle length");

	property p_no_start;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		rst_active_q && !wrcyc_busy_q |=> !wrcyc_busy_q;
	endproperty
	a_no_start: assert property (p_no_start) else $error("write in reset");

	property p_finish;
		@(posedge MCLK_I) disable iff (!RST_N_I)
		wrcyc_busy_q && wrcyc_cnt_q != ssv_pkg::CNT_W'(WRCYC_CYC - 1)
			|=> wrcyc_busy_q;
	endproperty
	a_finish: assert property (p_finish) else $error("write cut short");

	// Checks, link domain
	property p_spike;
		@(posedge LCLK_I) disable iff (!LRST_N_I)
		filt.scl && raw_s.scl ##1 !raw_s.scl [*7] ##1 raw_s.scl
			|=> filt.scl [*3];
	endproperty
	a_spike: assert property (p_spike) else $error("spike passed");

	property p_lock;
		@(posedge LCLK_I) disable iff (!LRST_N_I)
		lrst_active_s || lbusy_s |=> !BUS_EN_O ##1 !SDA_OE_O;
	endproperty
	a_lock: assert property (p_lock) else $error("bus not locked");

endmodule : ssv_supervisor
`default_nettype wire

// >>> ssv_host.sv
// Host model: two-wire bus master and push-button on the reset net.
// Assumes pull-ups on both bus lines and on the reset net.
`timescale 1ns/1ps
`default_nettype none
module ssv_host (
	input wire logic lclk_i,
	input wire logic sda_oe_i,
	input wire logic rst_oe_i,
	output logic scl_o,
	output logic sda_o,
	output logic rst_o
);
	logic scl_low = 1'b0;
	logic sda_low = 1'b0;
	logic button_low = 1'b0;
	// Released lines float to the pull-up level
	assign scl_o = ~scl_low;
	assign sda_o = ~(sda_low | sda_oe_i);
	assign rst_o = ~(button_low | rst_oe_i);
	task automatic lines(input logic c, input logic d, input int n);
		@(posedge lclk_i);
		#1;
		scl_low = ~c;
		sda_low = ~d;
		repeat (n) @(posedge lclk_i);
	endtask : lines
	// Patient host waits out reset; impatient one breaks in on purpose
	task automatic start_stop(input bit patient);
		for (int i = 0; patient && !rst_o && i < 2000; i++) @(posedge lclk_i);
		lines(1'b1, 1'b0, 40);
		lines(1'b0, 1'b0, 40);
		lines(1'b1, 1'b0, 40);
		lines(1'b1, 1'b1, 1);
	endtask : start_stop
	// Button low for w ns; cannot release a net the device drives
	task automatic push(input int w);
		button_low = 1'b1;
		#(w);
		button_low = 1'b0;
	endtask : push
endmodule : ssv_host
`default_nettype wire

// >>> tb.sv
// Testbench of the supply reset supervisor with a host model.
// Assumes shortened timeout and write cycle parameters.
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam int C = 200;
	localparam int W = 50;
	logic mclk = 1'b0;
	logic lclk = 1'b1;
	logic rst_n = 1'b0;
	logic lrst_n = 1'b0;
	logic supply = 1'b0;
	logic sda_drive = 1'b0;
	logic wr_data = 1'b0;
	wire logic scl;
	wire logic sda;
	wire logic rst_pin;
	logic rst_oe, busy, sda_oe, start, stop, bus_en;
	logic rst_do, sda_do;
	ssv_pkg::ssv_lines_type lines;
	int fails = 0;
	int checks = 0;
	int n_start = 0;
	int n_stop = 0;
	int n_low = 0;
	int n;
	always #2.5 mclk = ~mclk;
	// Link clock starts high so its rising edges sit between timer rising edges
	always #7.5 lclk = ~lclk;
	ssv_supervisor #(.TIMEOUT_CYC(C), .WRCYC_CYC(W)) i_ssv_supervisor (
		.MCLK_I(mclk), .RST_N_I(rst_n), .LCLK_I(lclk), .LRST_N_I(lrst_n),
		.SUPPLY_GOOD_I(supply), .RST_PIN_I(rst_pin), .RST_PIN_O(rst_do),
		.RST_PIN_OE_O(rst_oe), .WRCYC_BUSY_O(busy), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_do), .SDA_OE_O(sda_oe),
		.SDA_DRIVE_I(sda_drive),
		.WR_DATA_I(wr_data), .LINES_O(lines), .START_O(start),
		.STOP_O(stop), .BUS_EN_O(bus_en));
	ssv_host i_ssv_host (.lclk_i(lclk), .sda_oe_i(sda_oe),
		.rst_oe_i(rst_oe), .scl_o(scl), .sda_o(sda), .rst_o(rst_pin));
	always @(posedge lclk) begin
		if (start === 1'b1) n_start <= n_start + 1;
		if (stop === 1'b1) n_stop <= n_stop + 1;
		if (lines !== 2'b11) n_low <= n_low + 1;
	end
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask : tick
	task automatic report_and_stop();
		if (fails == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("BAD %0t %s", $time, m);
		end
	endtask : chk
	function automatic logic sig(input int k);
		case (k)
			0: return rst_oe;
			1: return busy;
			default: return bus_en;
		endcase
	endfunction : sig
	// Bounded wait; n holds the timer cycles spent
	task automatic wt(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v) begin
			if (n == lim) begin
				chk(1'b0, "wait ran out");
				report_and_stop();
			end
			tick(1);
			n++;
		end
	endtask : wt
	task automatic t_power();
		tick(300);
		chk(rst_oe === 1'b1, "reset dropped with supply low");
		chk(rst_do === 1'b0 && sda_do === 1'b0, "drive level not low");
		supply = 1'b1;
		wt(0, 1'b0, C + 40);
		chk(n >= C && n <= C + 20, "timeout length");
	endtask : t_power
	task automatic t_supply();
		supply = 1'b0;
		tick(6);
		supply = 1'b1;
		tick(60);
		chk(rst_oe === 1'b0, "short dip gave reset");
		supply = 1'b0;
		wt(0, 1'b1, 1000);
		chk(n > 6 && n <= 1000, "supply loss reaction");
		supply = 1'b1;
		wt(0, 1'b0, C + 40);
	endtask : t_supply
	task automatic t_manual();
		int w[3] = '{100, 150, 5000};
		for (int i = 0; i < 3; i++) begin
			fork
				i_ssv_host.push(w[i]);
			join_none
			tick(40);
			chk(rst_oe === (i > 0), "manual width wrong");
			if (i > 0) begin
				wt(0, 1'b0, C);
				chk(n >= C - 20 && n <= C - 8, "timeout after edge");
			end
			tick(1100);
			chk(rst_oe === 1'b0, "held pin retriggered");
		end
	endtask : t_manual
	task automatic t_spike();
		n_low = 0;
		n_start = 0;
		n_stop = 0;
		i_ssv_host.lines(1'b0, 1'b1, 6);
		i_ssv_host.lines(1'b1, 1'b0, 6);
		i_ssv_host.lines(1'b1, 1'b1, 20);
		chk(n_low == 0 && n_start == 0, "spike passed");
		i_ssv_host.start_stop(1'b1);
		i_ssv_host.lines(1'b1, 1'b1, 20);
		chk(n_start == 1 && n_stop == 1, "start or stop lost");
	endtask : t_spike
	task automatic t_write();
		wr_data = 1'b1;
		i_ssv_host.start_stop(1'b1);
		wt(1, 1'b1, 60);
		wr_data = 1'b0;
		sda_drive = 1'b1;
		tick(6);
		chk(sda_oe === 1'b0 && bus_en === 1'b0, "bus live in write");
		wt(1, 1'b0, W + 10);
		chk(n == W - 6, "write cycle length");
		wt(2, 1'b1, 40);
		tick(4);
		chk(sda_oe === 1'b1, "drive lost after write");
		sda_drive = 1'b0;
		// Let the stop from our own release pass before write data rises
		tick(60);
	endtask : t_write
	task automatic t_lock();
		wr_data = 1'b1;
		i_ssv_host.start_stop(1'b1);
		wt(1, 1'b1, 60);
		supply = 1'b0;
		wt(1, 1'b0, W + 10);
		chk(n == W, "write cut by reset");
		wt(0, 1'b1, 1000);
		tick(10);
		chk(bus_en === 1'b0, "bus open in reset");
		n_start = 0;
		// Impatient host talks into a held reset
		i_ssv_host.start_stop(1'b0);
		tick(40);
		chk(busy === 1'b0 && n_start == 0, "write begun in reset");
		wr_data = 1'b0;
		supply = 1'b1;
		wt(0, 1'b0, C + 40);
	endtask : t_lock
	initial begin
		tick(6);
		rst_n = 1'b1;
		tick(6);
		lrst_n = 1'b1;
		t_power();
		t_supply();
		t_manual();
		t_spike();
		t_write();
		t_lock();
		report_and_stop();
	end
endmodule : tb
`default_nettype wire
